// ==== plgm_pkg.sv ====
// constants, types and register map of the port loop guard and mirror block
// What this block does
// RQ1: probe each enabled port every two seconds
// RQ2: own probe returning on sender port blocks it
// RQ3: re-enable and reprobe after recovery interval
// RQ4: recovery interval 1 to 60 minutes, default 1
// RQ5: per-port auto recovery, default on, gates re-enable
// RQ6: global loop enable gates probing and blocking
// RQ7: per-port loop enable, default off
// RQ8: probes go to configurable destination address
// RQ9: every loop shutdown raises a reportable event
// RQ10: expose blocked, enable, recovery setting and interval
// RQ11: ingress mirror copies source receive frames to monitor
// RQ12: egress mirror copies source transmit frames to monitor
// RQ13: monitor port may never be a mirror source
// RQ14: trunk member port refused as monitor port
// RQ15: chosen monitor port drops out of source set
// RQ16: global mirror enable gates all copying
// RQ17: without negotiation sense speed, run half duplex
// RQ18: full duplex flow control sends pause on full buffer
// RQ19: half duplex flow control jams with collision
// RQ20: crossover detection only under full auto negotiation
// RQ21: negotiation advertises and uses configured speed, duplex
// RQ22: manual recovery command unblocks port, resumes probing
package plgm_pkg;
  // =====================================================================
  // sizes
  localparam int PLGM_NPORT = 10;
  localparam int PLGM_PW = 4;
  localparam int PLGM_AW = 8;
  localparam int PLGM_DW = 32;
  localparam int PLGM_MACW = 48;
  localparam int PLGM_MACLO = 32;
  localparam int PLGM_RTW = 7;
  localparam int PLGM_SPW = 2;
  localparam int PLGM_TMRW = 40;
  localparam int PLGM_SYNC = 3;
  // =====================================================================
  // timing
  localparam longint PLGM_CLK_HZ = 250_000_000;
  localparam longint PLGM_PROBE_S = 2;
  localparam longint PLGM_MINUTE_S = 60;
  localparam longint PLGM_PROBE_CYC = PLGM_PROBE_S * PLGM_CLK_HZ;
  localparam longint PLGM_MINUTE_CYC = PLGM_MINUTE_S * PLGM_CLK_HZ;
  localparam logic [PLGM_RTW-1:0] PLGM_REC_MIN = 7'h01;
  localparam logic [PLGM_RTW-1:0] PLGM_REC_MAX = 7'h3c;
  localparam logic [PLGM_RTW-1:0] PLGM_REC_DEF = 7'h01;
  // =====================================================================
  // register byte offsets
  localparam logic [PLGM_AW-1:0] PLGM_R_CTRL = 8'h00;
  localparam logic [PLGM_AW-1:0] PLGM_R_MAC_LO = 8'h04;
  localparam logic [PLGM_AW-1:0] PLGM_R_MAC_HI = 8'h08;
  localparam logic [PLGM_AW-1:0] PLGM_R_LD_EN = 8'h0c;
  localparam logic [PLGM_AW-1:0] PLGM_R_AUTO_REC = 8'h10;
  localparam logic [PLGM_AW-1:0] PLGM_R_BLOCKED = 8'h14;
  localparam logic [PLGM_AW-1:0] PLGM_R_LOOP_EVT = 8'h18;
  localparam logic [PLGM_AW-1:0] PLGM_R_MAN_REC = 8'h1c;
  localparam logic [PLGM_AW-1:0] PLGM_R_REC_T0 = 8'h20;
  localparam logic [PLGM_AW-1:0] PLGM_R_REC_TN = 8'h44;
  localparam logic [PLGM_AW-1:0] PLGM_R_MIR_ING = 8'h48;
  localparam logic [PLGM_AW-1:0] PLGM_R_MIR_EGR = 8'h4c;
  localparam logic [PLGM_AW-1:0] PLGM_R_MIR_DST = 8'h50;
  localparam logic [PLGM_AW-1:0] PLGM_R_TRUNK = 8'h54;
  localparam logic [PLGM_AW-1:0] PLGM_R_MIR_ERR = 8'h58;
  localparam logic [PLGM_AW-1:0] PLGM_R_AN_EN = 8'h5c;
  localparam logic [PLGM_AW-1:0] PLGM_R_FC_EN = 8'h60;
  localparam logic [PLGM_AW-1:0] PLGM_R_CFG_SPD = 8'h64;
  localparam logic [PLGM_AW-1:0] PLGM_R_CFG_FDX = 8'h68;
  localparam logic [PLGM_AW-1:0] PLGM_R_ST_SPD = 8'h6c;
  localparam logic [PLGM_AW-1:0] PLGM_R_ST_FDX = 8'h70;
  // =====================================================================
  // fields and reset values
  localparam int PLGM_CTRL_LD = 0;
  localparam int PLGM_CTRL_MIR = 1;
  localparam int PLGM_ERR_SRC = 0;
  localparam int PLGM_ERR_DST = 1;
  localparam int PLGM_ERRW = 2;
  localparam logic [PLGM_NPORT-1:0] PLGM_MASK_NONE = 10'h000;
  localparam logic [PLGM_NPORT-1:0] PLGM_MASK_ALL = 10'h3ff;
  localparam logic [PLGM_SPW-1:0] PLGM_SPD_10 = 2'h0;
  localparam logic [PLGM_SPW-1:0] PLGM_SPD_100 = 2'h1;
  localparam logic [PLGM_SPW-1:0] PLGM_SPD_1000 = 2'h2;
  localparam logic [PLGM_MACW-1:0] PLGM_MAC_DEF = 48'h0;
  // =====================================================================
  // types
  typedef logic [PLGM_NPORT-1:0] plgm_mask_t;
  typedef logic [PLGM_PW-1:0] plgm_port_t;
  typedef logic [PLGM_NPORT*PLGM_SPW-1:0] plgm_spd_t;
  typedef enum logic [2:0] {
    PLGM_LD_OFF = 3'b001,
    PLGM_LD_PROBE = 3'b010,
    PLGM_LD_BLOCK = 3'b100
  } plgm_ld_e;
  typedef struct packed {
    logic valid;
    plgm_port_t port;
    plgm_port_t origin;
    logic is_probe;
    logic [PLGM_MACW-1:0] da;
  } plgm_rx_evt_s;
  typedef struct packed {
    logic valid;
    plgm_port_t port;
  } plgm_frm_s;
  typedef struct packed {
    logic valid;
    plgm_port_t src;
    plgm_port_t dst;
  } plgm_copy_s;
endpackage : plgm_pkg

// ==== plgm_port_loop_guard.sv ====
// per-port loop guard, traffic mirror and link/flow control of the switch
module plgm_port_loop_guard
  import plgm_pkg::*;
#(
  parameter logic [PLGM_TMRW-1:0] PROBE_CYC = PLGM_TMRW'(PLGM_PROBE_CYC),
  parameter logic [PLGM_TMRW-1:0] MINUTE_CYC = PLGM_TMRW'(PLGM_MINUTE_CYC)
) (
  input wire logic ref_clk_in, // 250 mhz clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [PLGM_AW-1:0] addr_in, // register byte address
  input wire logic [PLGM_DW-1:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [PLGM_DW-1:0] rdata_out, // read data, cycle after strobe
  input wire plgm_rx_evt_s probe_rx_in, // received loop probe frame
  output plgm_mask_t probe_tx_out, // send one probe on port, pulse
  output logic [PLGM_MACW-1:0] probe_da_out, // probe destination address
  output plgm_mask_t port_dis_out, // port shut by loop guard
  output plgm_frm_s loop_evt_out, // loop shutdown event, pulse
  input wire plgm_frm_s rx_frm_in, // frame received on port
  input wire plgm_frm_s tx_frm_in, // frame sent on port
  output plgm_copy_s mir_ing_out, // ingress copy to monitor port
  output plgm_copy_s mir_egr_out, // egress copy to monitor port
  input wire plgm_mask_t partner_an_in, // pin: partner negotiates
  input wire plgm_spd_t line_spd_in, // pin: sensed line speed
  input wire plgm_mask_t buf_full_in, // receive buffers full
  output plgm_mask_t pause_out, // send pause frame, pulse
  output plgm_mask_t jam_out, // drive collision, level
  output plgm_spd_t spd_out, // resolved speed
  output plgm_mask_t fdx_out, // resolved full duplex
  output plgm_spd_t adv_spd_out, // advertised speed
  output plgm_mask_t adv_fdx_out, // advertised full duplex
  output plgm_mask_t mdix_en_out // crossover detection enable
);

  function automatic plgm_mask_t port_bit(input plgm_port_t p);
    port_bit = PLGM_MASK_NONE;
    if (p < PLGM_PW'(PLGM_NPORT)) begin
      port_bit[p] = 1'b1;
    end
  endfunction : port_bit

  // =====================================================================
  // register file
  logic ld_glob_ff, mir_en_ff;
  logic [PLGM_MACW-1:0] mac_ff;
  plgm_mask_t ld_en_ff, auto_rec_ff, evt_sticky_ff, man_rec_ff;
  plgm_mask_t ing_ff, egr_ff, trunk_ff, an_en_ff, fc_en_ff, cfg_fdx_ff;
  plgm_spd_t cfg_spd_ff;
  plgm_port_t dst_ff;
  logic [PLGM_ERRW-1:0] err_ff;
  logic [PLGM_RTW-1:0] rec_t_ff [PLGM_NPORT];
  plgm_ld_e st_ff [PLGM_NPORT];
  plgm_ld_e nxt_st [PLGM_NPORT];
  plgm_mask_t loop_hit_w, blocked_w, rec_done_w;

  wire plgm_mask_t wd_mask = wdata_in[PLGM_NPORT-1:0];
  wire plgm_port_t wd_port = wdata_in[PLGM_PW-1:0];
  wire logic [PLGM_RTW-1:0] wd_rec = wdata_in[PLGM_RTW-1:0];
  wire logic wr_ctrl = wr_in && addr_in == PLGM_R_CTRL;
  wire logic wr_ing = wr_in && addr_in == PLGM_R_MIR_ING;
  wire logic wr_egr = wr_in && addr_in == PLGM_R_MIR_EGR;
  wire logic wr_dst = wr_in && addr_in == PLGM_R_MIR_DST;
  wire logic wr_evt = wr_in && addr_in == PLGM_R_LOOP_EVT;
  wire logic wr_err = wr_in && addr_in == PLGM_R_MIR_ERR;
  wire logic wr_man = wr_in && addr_in == PLGM_R_MAN_REC;
  wire logic rec_range = addr_in >= PLGM_R_REC_T0 && addr_in <= PLGM_R_REC_TN;
  wire logic rec_hit = rec_range && addr_in[1:0] == 2'h0;
  wire logic [PLGM_AW-1:0] rec_off = addr_in - PLGM_R_REC_T0;
  wire plgm_port_t rec_idx = rec_off[PLGM_PW+1:2];
  wire logic rec_val_ok = wd_rec >= PLGM_REC_MIN && wd_rec <= PLGM_REC_MAX; // [RQ4]
  wire plgm_mask_t dst_bit = port_bit(dst_ff);
  wire plgm_mask_t new_dst_bit = port_bit(wd_port);
  // a source set that names the monitor port is refused whole
  wire logic ing_bad = (wd_mask & dst_bit) != PLGM_MASK_NONE; // [RQ13]
  wire logic egr_bad = (wd_mask & dst_bit) != PLGM_MASK_NONE; // [RQ13]
  wire logic dst_bad = (new_dst_bit & trunk_ff) != PLGM_MASK_NONE
                       || new_dst_bit == PLGM_MASK_NONE; // [RQ14]
  wire logic [PLGM_ERRW-1:0] err_set = {wr_dst && dst_bad,
                                         (wr_ing && ing_bad) || (wr_egr && egr_bad)};
  wire plgm_mask_t nxt_ing = wr_dst && !dst_bad ? ing_ff & ~new_dst_bit : // [RQ15]
                             wr_ing && !ing_bad ? wd_mask : ing_ff;
  wire plgm_mask_t nxt_egr = wr_dst && !dst_bad ? egr_ff & ~new_dst_bit : // [RQ15]
                             wr_egr && !egr_bad ? wd_mask : egr_ff;
  // set wins over write-one-to-clear so no shutdown report is lost
  wire plgm_mask_t nxt_evt = (evt_sticky_ff & ~(wr_evt ? wd_mask : PLGM_MASK_NONE))
                             | loop_hit_w; // [RQ9]
  wire logic [PLGM_ERRW-1:0] nxt_err = (err_ff & ~(wr_err ? wdata_in[PLGM_ERRW-1:0]
                                        : {PLGM_ERRW{1'b0}})) | err_set;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ld_glob_ff <= 1'b0;
      mir_en_ff <= 1'b0;
      mac_ff <= PLGM_MAC_DEF;
      ld_en_ff <= PLGM_MASK_NONE; // [RQ7]
      auto_rec_ff <= PLGM_MASK_ALL; // [RQ5]
      evt_sticky_ff <= PLGM_MASK_NONE;
      man_rec_ff <= PLGM_MASK_NONE;
      ing_ff <= PLGM_MASK_NONE;
      egr_ff <= PLGM_MASK_NONE;
      dst_ff <= '0;
      trunk_ff <= PLGM_MASK_NONE;
      err_ff <= '0;
      an_en_ff <= PLGM_MASK_ALL;
      fc_en_ff <= PLGM_MASK_ALL;
      cfg_spd_ff <= {PLGM_NPORT{PLGM_SPD_1000}};
      cfg_fdx_ff <= PLGM_MASK_ALL;
      for (int p = 0; p < PLGM_NPORT; p++) begin
        rec_t_ff[p] <= PLGM_REC_DEF; // [RQ4]
      end
    end else begin
      if (wr_ctrl) begin
        ld_glob_ff <= wdata_in[PLGM_CTRL_LD];
        mir_en_ff <= wdata_in[PLGM_CTRL_MIR];
      end
      if (wr_in && addr_in == PLGM_R_MAC_LO) begin
        mac_ff[PLGM_MACLO-1:0] <= wdata_in; // [RQ8]
      end
      if (wr_in && addr_in == PLGM_R_MAC_HI) begin
        mac_ff[PLGM_MACW-1:PLGM_MACLO] <= wdata_in[PLGM_MACW-PLGM_MACLO-1:0];
      end
      if (wr_in && addr_in == PLGM_R_LD_EN) begin
        ld_en_ff <= wd_mask;
      end
      if (wr_in && addr_in == PLGM_R_AUTO_REC) begin
        auto_rec_ff <= wd_mask;
      end
      if (wr_in && rec_hit && rec_val_ok) begin
        rec_t_ff[rec_idx] <= wd_rec; // [RQ4]
      end
      evt_sticky_ff <= nxt_evt;
      man_rec_ff <= wr_man ? wd_mask : PLGM_MASK_NONE; // [RQ22]
      ing_ff <= nxt_ing;
      egr_ff <= nxt_egr;
      if (wr_dst && !dst_bad) begin
        dst_ff <= wd_port;
      end
      if (wr_in && addr_in == PLGM_R_TRUNK) begin
        trunk_ff <= wd_mask;
      end
      err_ff <= nxt_err;
      if (wr_in && addr_in == PLGM_R_AN_EN) begin
        an_en_ff <= wd_mask;
      end
      if (wr_in && addr_in == PLGM_R_FC_EN) begin
        fc_en_ff <= wd_mask;
      end
      if (wr_in && addr_in == PLGM_R_CFG_SPD) begin
        cfg_spd_ff <= wdata_in[PLGM_NPORT*PLGM_SPW-1:0];
      end
      if (wr_in && addr_in == PLGM_R_CFG_FDX) begin
        cfg_fdx_ff <= wd_mask;
      end
    end
  end

  // =====================================================================
  // read path
  logic [PLGM_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (rec_hit) begin
      rd_mux[PLGM_RTW-1:0] = rec_t_ff[rec_idx]; // [RQ10]
    end else begin
      unique case (addr_in)
        PLGM_R_CTRL: rd_mux[PLGM_CTRL_MIR:PLGM_CTRL_LD] = {mir_en_ff, ld_glob_ff};
        PLGM_R_MAC_LO: rd_mux = mac_ff[PLGM_MACLO-1:0];
        PLGM_R_MAC_HI: rd_mux[PLGM_MACW-PLGM_MACLO-1:0] = mac_ff[PLGM_MACW-1:PLGM_MACLO];
        PLGM_R_LD_EN: rd_mux[PLGM_NPORT-1:0] = ld_en_ff; // [RQ10]
        PLGM_R_AUTO_REC: rd_mux[PLGM_NPORT-1:0] = auto_rec_ff; // [RQ10]
        PLGM_R_BLOCKED: rd_mux[PLGM_NPORT-1:0] = port_dis_out; // [RQ10]
        PLGM_R_LOOP_EVT: rd_mux[PLGM_NPORT-1:0] = evt_sticky_ff;
        PLGM_R_MIR_ING: rd_mux[PLGM_NPORT-1:0] = ing_ff;
        PLGM_R_MIR_EGR: rd_mux[PLGM_NPORT-1:0] = egr_ff;
        PLGM_R_MIR_DST: rd_mux[PLGM_PW-1:0] = dst_ff;
        PLGM_R_TRUNK: rd_mux[PLGM_NPORT-1:0] = trunk_ff;
        PLGM_R_MIR_ERR: rd_mux[PLGM_ERRW-1:0] = err_ff;
        PLGM_R_AN_EN: rd_mux[PLGM_NPORT-1:0] = an_en_ff;
        PLGM_R_FC_EN: rd_mux[PLGM_NPORT-1:0] = fc_en_ff;
        PLGM_R_CFG_SPD: rd_mux[PLGM_NPORT*PLGM_SPW-1:0] = cfg_spd_ff;
        PLGM_R_CFG_FDX: rd_mux[PLGM_NPORT-1:0] = cfg_fdx_ff;
        PLGM_R_ST_SPD: rd_mux[PLGM_NPORT*PLGM_SPW-1:0] = spd_out;
        PLGM_R_ST_FDX: rd_mux[PLGM_NPORT-1:0] = fdx_out;
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rd_in ? rd_mux : '0;
    end
  end

  // =====================================================================
  // probe and minute timebases, shared by all ports
  logic [PLGM_TMRW-1:0] probe_cnt_ff, min_cnt_ff;
  wire logic probe_tick = probe_cnt_ff == PROBE_CYC - 1'b1; // [RQ1]
  wire logic min_tick = min_cnt_ff == MINUTE_CYC - 1'b1;
  logic [PLGM_RTW-1:0] rec_cnt_ff [PLGM_NPORT];

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      probe_cnt_ff <= '0;
      min_cnt_ff <= '0;
    end else begin
      probe_cnt_ff <= probe_tick ? '0 : probe_cnt_ff + 1'b1;
      min_cnt_ff <= min_tick ? '0 : min_cnt_ff + 1'b1;
    end
  end

  // =====================================================================
  // loop guard per port
  // minute ticks are shared, so waiting for interval+1 ticks keeps the
  // hold-off at least the full interval, at most one minute longer
  wire logic rx_loop = probe_rx_in.valid && probe_rx_in.is_probe
                       && probe_rx_in.da == mac_ff // [RQ8]
                       && probe_rx_in.origin == probe_rx_in.port; // [RQ2]
  wire plgm_mask_t rx_port_bit = port_bit(probe_rx_in.port);

  always_comb begin
    for (int p = 0; p < PLGM_NPORT; p++) begin
      // a hit in the cycle the enables drop must not block the port
      loop_hit_w[p] = rx_loop && rx_port_bit[p] && st_ff[p] == PLGM_LD_PROBE
                      && ld_glob_ff && ld_en_ff[p]; // [RQ2] [RQ6]
      blocked_w[p] = st_ff[p] == PLGM_LD_BLOCK;
      rec_done_w[p] = auto_rec_ff[p] && rec_cnt_ff[p] > rec_t_ff[p]; // [RQ3] [RQ5]
      nxt_st[p] = st_ff[p];
      unique case (st_ff[p])
        PLGM_LD_OFF: if (ld_glob_ff && ld_en_ff[p]) nxt_st[p] = PLGM_LD_PROBE;
        PLGM_LD_PROBE: begin
          if (loop_hit_w[p]) begin
            nxt_st[p] = PLGM_LD_BLOCK; // [RQ2]
          end else if (!ld_glob_ff || !ld_en_ff[p]) begin
            nxt_st[p] = PLGM_LD_OFF; // [RQ6] [RQ7]
          end
        end
        PLGM_LD_BLOCK: begin
          if (!ld_glob_ff || !ld_en_ff[p]) begin
            nxt_st[p] = PLGM_LD_OFF; // [RQ6] [RQ7]
          end else if (rec_done_w[p] || man_rec_ff[p]) begin
            nxt_st[p] = PLGM_LD_PROBE; // [RQ3] [RQ22]
          end
        end
        default: nxt_st[p] = PLGM_LD_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int p = 0; p < PLGM_NPORT; p++) begin
        st_ff[p] <= PLGM_LD_OFF;
        rec_cnt_ff[p] <= '0;
      end
      probe_tx_out <= PLGM_MASK_NONE;
      port_dis_out <= PLGM_MASK_NONE;
      loop_evt_out <= '0;
      probe_da_out <= PLGM_MAC_DEF;
    end else begin
      for (int p = 0; p < PLGM_NPORT; p++) begin
        st_ff[p] <= nxt_st[p];
        rec_cnt_ff[p] <= !blocked_w[p] ? '0 :
                         (min_tick && rec_cnt_ff[p] <= rec_t_ff[p]) ? rec_cnt_ff[p] + 1'b1 :
                         rec_cnt_ff[p];
        probe_tx_out[p] <= probe_tick && nxt_st[p] == PLGM_LD_PROBE; // [RQ1]
        port_dis_out[p] <= nxt_st[p] == PLGM_LD_BLOCK; // [RQ2]
      end
      loop_evt_out.valid <= rx_loop && loop_hit_w != PLGM_MASK_NONE; // [RQ9]
      loop_evt_out.port <= probe_rx_in.port;
      probe_da_out <= mac_ff; // [RQ8]
    end
  end

  // =====================================================================
  // mirroring
  wire logic ing_hit = mir_en_ff && rx_frm_in.valid
                       && (port_bit(rx_frm_in.port) & ing_ff) != PLGM_MASK_NONE; // [RQ11] [RQ16]
  wire logic egr_hit = mir_en_ff && tx_frm_in.valid
                       && (port_bit(tx_frm_in.port) & egr_ff) != PLGM_MASK_NONE; // [RQ12] [RQ16]

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mir_ing_out <= '0;
      mir_egr_out <= '0;
    end else begin
      mir_ing_out <= '{valid: ing_hit, src: rx_frm_in.port, dst: dst_ff}; // [RQ11]
      mir_egr_out <= '{valid: egr_hit, src: tx_frm_in.port, dst: dst_ff}; // [RQ12]
    end
  end

  // =====================================================================
  // link resolution and flow control
  // pin inputs pass three flops; a change counts once stages two and three agree
  localparam int SW = PLGM_NPORT + PLGM_NPORT * PLGM_SPW;
  logic [SW-1:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
  wire plgm_mask_t an_ok_w = an_en_ff & pin_ff[PLGM_NPORT-1:0];
  wire plgm_spd_t sensed_w = pin_ff[SW-1:PLGM_NPORT];
  plgm_mask_t full_d_ff;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pin_ff <= '0;
      spd_out <= '0;
      fdx_out <= PLGM_MASK_NONE;
      adv_spd_out <= '0;
      adv_fdx_out <= PLGM_MASK_NONE;
      mdix_en_out <= PLGM_MASK_NONE;
      pause_out <= PLGM_MASK_NONE;
      jam_out <= PLGM_MASK_NONE;
      full_d_ff <= PLGM_MASK_NONE;
    end else begin
      sync1_ff <= {line_spd_in, partner_an_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        pin_ff <= sync3_ff;
      end
      for (int p = 0; p < PLGM_NPORT; p++) begin
        spd_out[p*PLGM_SPW +: PLGM_SPW] <= an_ok_w[p] ? cfg_spd_ff[p*PLGM_SPW +: PLGM_SPW]
                                          : sensed_w[p*PLGM_SPW +: PLGM_SPW]; // [RQ17] [RQ21]
      end
      fdx_out <= an_ok_w & cfg_fdx_ff; // [RQ17] [RQ21]
      adv_spd_out <= cfg_spd_ff; // [RQ21]
      adv_fdx_out <= cfg_fdx_ff & an_en_ff; // [RQ21]
      mdix_en_out <= an_en_ff; // [RQ20]
      full_d_ff <= buf_full_in;
      // pause once per fill; the partner's pause timer carries the hold
      pause_out <= buf_full_in & ~full_d_ff & fc_en_ff & fdx_out; // [RQ18]
      jam_out <= buf_full_in & fc_en_ff & ~fdx_out; // [RQ19]
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  a_probe_glob_gate: assert property ((probe_tx_out != 0) |-> $past(ld_glob_ff)) // [RQ6]
    else $error("probe sent while loop guard off");
  a_probe_port_gate: assert property ((probe_tx_out & ~$past(ld_en_ff)) == 0) // [RQ7]
    else $error("probe sent on port without loop enable");
  a_loop_blocks_port: assert property ((loop_hit_w != 0) |=>
    ((port_dis_out & $past(loop_hit_w)) == $past(loop_hit_w))) // [RQ2]
    else $error("returned probe did not block port");
  a_loop_event_raised: assert property ((loop_hit_w != 0) |=>
    loop_evt_out.valid && (evt_sticky_ff & $past(loop_hit_w)) != 0) // [RQ9]
    else $error("loop shutdown without event");
  a_no_block_off: assert property (!ld_glob_ff |=> port_dis_out == 0) // [RQ6]
    else $error("port blocked while loop guard off");
  a_block_holds_manual: assert property (((port_dis_out & ~auto_rec_ff) != 0) && man_rec_ff == 0
    && ld_glob_ff && !wr_ctrl |=> ((port_dis_out & $past(port_dis_out & ~auto_rec_ff))
    == $past(port_dis_out & ~auto_rec_ff))) // [RQ5]
    else $error("port left block without recovery");
  a_ing_copy_made: assert property (ing_hit |=> mir_ing_out.valid
    && mir_ing_out.src == $past(rx_frm_in.port)) // [RQ11]
    else $error("ingress frame not mirrored");
  a_mirror_gated: assert property ((mir_ing_out.valid || mir_egr_out.valid)
    |-> $past(mir_en_ff)) // [RQ16]
    else $error("copy made while mirror off");
  a_dst_not_source: assert property (((ing_ff | egr_ff) & dst_bit) == 0) // [RQ13]
    else $error("monitor port is a mirror source");
  a_dst_not_trunk: assert property (wr_dst && dst_bad |=> dst_ff == $past(dst_ff)) // [RQ14]
    else $error("trunk port taken as monitor");
  a_half_no_neg: assert property ((fdx_out & ~$past(an_ok_w)) == 0) // [RQ17]
    else $error("full duplex without negotiation");
  a_jam_half_only: assert property ((jam_out & $past(fdx_out)) == 0) // [RQ19]
    else $error("collision jam in full duplex");

  c_loop_block: cover property ((loop_hit_w != 0) ##1 (port_dis_out != 0));
  c_auto_recover: cover property ((port_dis_out != 0) ##1 (port_dis_out == 0) && ld_glob_ff);
  c_mirror_both: cover property (mir_ing_out.valid && mir_egr_out.valid);
  c_pause_sent: cover property (pause_out != 0);

endmodule : plgm_port_loop_guard

// ==== plgm_net_model.sv ====
// network model: a cabled loop returns a probe to the port that sent it, only the highest-numbered such port per cycle
module plgm_net_model
  import plgm_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire plgm_mask_t loop_in, // ports cabled into a loop
  input wire plgm_mask_t probe_tx_in, // probes leaving the switch
  input wire logic [PLGM_MACW-1:0] da_in, // probe destination
  output plgm_rx_evt_s probe_rx_out // probe coming back, pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial probe_rx_out = '0;
  always @(posedge ref_clk_in) begin
    probe_rx_out <= '0;
    for (int p = 0; p < PLGM_NPORT; p++) begin
      if (probe_tx_in[p] && loop_in[p]) begin
        probe_rx_out <= {1'b1, PLGM_PW'(p), PLGM_PW'(p), 1'b1, da_in};
      end
    end
  end
endmodule : plgm_net_model

// ==== testbench.sv ====
// self-checking bench of the loop guard and mirror
module testbench;
  import plgm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, wr = 0, rd = 0;
  logic [7:0] addr = '0;
  logic [31:0] wd = '0, rdata;
  plgm_mask_t loop = '0, dis, ptx;
  plgm_rx_evt_s prx;
  plgm_frm_s rxf = '0, evt;
  plgm_copy_s ming, megr;
  plgm_mask_t full = '0, pan = '0, pz, jz, fz, mdx;
  plgm_spd_t sz;
  plgm_frm_s txf = '0;
  logic [47:0] da;
  int failures = 0, comparisons = 0;
  plgm_port_loop_guard #(.PROBE_CYC(40'h10), .MINUTE_CYC(40'h40)) plgm_port_loop_guard_inst (
    .ref_clk_in(clk), .resetn_in(rstn), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .probe_rx_in(prx), .probe_tx_out(ptx),
    .probe_da_out(da), .port_dis_out(dis), .loop_evt_out(evt), .rx_frm_in(rxf),
    .tx_frm_in(txf), .mir_ing_out(ming), .mir_egr_out(megr), .partner_an_in(pan),
    .line_spd_in('0), .buf_full_in(full), .pause_out(pz), .jam_out(jz), .spd_out(sz),
    .fdx_out(fz), .adv_spd_out(), .adv_fdx_out(), .mdix_en_out(mdx));
  plgm_net_model plgm_net_model_inst (.ref_clk_in(clk), .loop_in(loop),
    .probe_tx_in(ptx), .da_in(da), .probe_rx_out(prx));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(rdata, exp);
  endtask : rdr
  task automatic wait3(input logic v, input int n);
    while (dis[3] !== v && n > 0) begin
      @(posedge clk) #1 n--;
    end
    chk(dis[3], v);
  endtask : wait3
  // =====================================================================
  task automatic t_loop_recover;
    rdr(PLGM_R_AUTO_REC, 32'h3ff);
    rdr(PLGM_R_REC_T0, 32'h1);
    rdr(8'hfc, 32'h0);
    wrr(PLGM_R_MAC_LO, 32'h0a0b0c0d);
    wrr(PLGM_R_LD_EN, 32'h8);
    loop <= 10'h008;
    repeat (50) @(posedge clk);
    #1 chk(dis, '0);
    wrr(PLGM_R_CTRL, 32'h1);
    wait3(1'b1, 40);
    chk(evt, {1'b1, 4'h3});
    chk(da, 48'h0a0b0c0d);
    loop <= '0;
    rdr(PLGM_R_BLOCKED, 32'h8);
    rdr(PLGM_R_LOOP_EVT, 32'h8);
    repeat (55) @(posedge clk);
    #1 chk(dis[3], 1'b1);
    wait3(1'b0, 90);
  endtask : t_loop_recover
  task automatic t_manual;
    wrr(PLGM_R_AUTO_REC, 32'h0);
    loop <= 10'h008;
    wait3(1'b1, 40);
    loop <= '0;
    repeat (200) @(posedge clk);
    #1 chk(dis[3], 1'b1);
    wrr(PLGM_R_MAN_REC, 32'h8);
    // the recovery pulse is registered, so the block drops one edge later
    @(posedge clk) #1 chk(dis[3], 1'b0);
  endtask : t_manual
  task automatic t_mirror;
    wrr(PLGM_R_MIR_DST, 32'h5);
    wrr(PLGM_R_MIR_ING, 32'h4);
    @(posedge clk) rxf <= {1'b1, 4'h2};
    @(posedge clk) rxf <= '0;
    #1 chk(ming.valid, 1'b0);
    wrr(PLGM_R_CTRL, 32'h2);
    @(posedge clk) rxf <= {1'b1, 4'h2};
    @(posedge clk) rxf <= '0;
    #1 chk(ming, {1'b1, 4'h2, 4'h5});
    wrr(PLGM_R_MIR_ING, 32'h24);
    rdr(PLGM_R_MIR_ERR, 32'h1);
    rdr(PLGM_R_MIR_ING, 32'h4);
    wrr(PLGM_R_MIR_EGR, 32'h2);
    @(posedge clk) txf <= {1'b1, 4'h1};
    @(posedge clk) txf <= '0;
    #1 chk(megr, {1'b1, 4'h1, 4'h5});
    wrr(PLGM_R_TRUNK, 32'h8);
    wrr(PLGM_R_MIR_DST, 32'h3);
    rdr(PLGM_R_MIR_ERR, 32'h3);
    wrr(PLGM_R_MIR_DST, 32'h2);
    rdr(PLGM_R_MIR_ING, 32'h0);
    rdr(PLGM_R_MIR_DST, 32'h2);
  endtask : t_mirror
  task automatic t_link;
    @(posedge clk) full <= 10'h002;
    @(posedge clk) #1 chk(jz, 10'h002);
    chk(pz, '0);
    chk(fz, '0);
    @(posedge clk) {full, pan} <= {10'h000, 10'h002};
    // partner pin passes the three-flop filter before duplex resolves
    repeat (6) @(posedge clk);
    #1 chk(fz, 10'h002);
    chk(sz, 20'h00008);
    @(posedge clk) full <= 10'h002;
    @(posedge clk) #1 chk(pz, 10'h002);
    chk(jz, '0);
    @(posedge clk) full <= '0;
    #1 chk(pz, '0);
    wrr(PLGM_R_AN_EN, 32'h1);
    @(posedge clk) #1 chk(mdx, 10'h001);
    chk(fz, '0);
  endtask : t_link
  task automatic summarize;
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    t_loop_recover();
    t_manual();
    t_mirror();
    t_link();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : testbench
